// [logic/pie_top.sv]
// peripheral interrupt-enable mask with register port
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pie_top
  import pie_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [PIE_AW-1:0] reg_addr,
  input wire logic [PIE_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PIE_DW-1:0] reg_rdata,
  // source flags, levels
  input wire logic comparator_fall_flag,
  input wire logic counter_array_flag,
  input wire logic conversion_done_flag,
  input wire logic window_compare_flag,
  // gated requests toward the core
  output logic comparator_fall_req,
  output logic counter_array_req,
  output logic conversion_done_req,
  output logic window_compare_req,
  // summary interrupt
  output logic irq
);
  logic [PIE_NSRC-1:0] enable_reg;
  logic [PIE_NSRC-1:0] enable_next;
  logic [PIE_NSRC-1:0] irqmask_reg;
  logic [PIE_NSRC-1:0] irqmask_next;
  logic [PIE_DW-1:0] rdata_reg;
  logic [PIE_DW-1:0] rdata_next;
  logic [PIE_NSRC-1:0] flags;
  logic [PIE_NSRC-1:0] flags_d_reg;
  logic [PIE_NSRC-1:0] reqs;
  logic [PIE_NSRC-1:0] status;
  logic [PIE_NSRC-1:0] rise;
  wire comparator_fall_int_enable = enable_reg[PIE_BIT_CMPF];
  wire counter_array_int_enable = enable_reg[PIE_BIT_PCA];
  wire conversion_done_int_enable = enable_reg[PIE_BIT_CONV];
  wire window_compare_int_enable = enable_reg[PIE_BIT_WIN];

  // address match, shared by the strobes, the read mux and the checks
  function automatic logic hit(input logic [PIE_AW-1:0] a, input logic [PIE_AW-1:0] r);
    hit = (a == r);
  endfunction

  assign flags[PIE_BIT_CMPF] = comparator_fall_flag;
  assign flags[PIE_BIT_PCA] = counter_array_flag;
  assign flags[PIE_BIT_CONV] = conversion_done_flag;
  assign flags[PIE_BIT_WIN] = window_compare_flag;

  wire wr_enable = reg_wr & hit(reg_addr, PIE_ADDR_ENABLE);
  wire wr_irqmask = reg_wr & hit(reg_addr, PIE_ADDR_IRQMASK);
  wire rd_status = reg_rd & hit(reg_addr, PIE_ADDR_STATUS);
  assign enable_next = wr_enable ? reg_wdata[PIE_NSRC-1:0] : enable_reg;
  assign irqmask_next = wr_irqmask ? reg_wdata[PIE_NSRC-1:0] : irqmask_reg;
  // a request event is the rising edge of a forwarded request
  assign rise = reqs & ~flags_d_reg;
  // every address reads back; the raw flags let software see a pending source
  // that its mask still holds back
  assign rdata_next = !reg_rd ? '0 :
    hit(reg_addr, PIE_ADDR_ENABLE) ? {{(PIE_DW-PIE_NSRC){1'b0}}, enable_reg} :
    hit(reg_addr, PIE_ADDR_PENDING) ? {{(PIE_DW-PIE_NSRC){1'b0}}, flags} :
    hit(reg_addr, PIE_ADDR_STATUS) ? {{(PIE_DW-PIE_NSRC){1'b0}}, status} :
    {{(PIE_DW-PIE_NSRC){1'b0}}, irqmask_reg};

  always_ff @(posedge mclk) begin
    if (srst) begin
      enable_reg <= PIE_ENABLE_RST;
      irqmask_reg <= PIE_IRQMASK_RST;
      rdata_reg <= '0;
      flags_d_reg <= '0;
    end else begin
      enable_reg <= enable_next;
      irqmask_reg <= irqmask_next;
      rdata_reg <= rdata_next;
      flags_d_reg <= reqs;
    end
  end

  // requests leave from flip-flops, one cycle behind the flag, so the core sees no glitch
  pie_gate #(.N(PIE_NSRC)) u_gate (
    .mclk(mclk),
    .srst(srst),
    .flag(flags),
    .enable(enable_reg),
    .req(reqs)
  );

  // status sees only the edge of a forwarded request, so a held flag counts once
  pie_status #(.N(PIE_NSRC)) u_status (
    .mclk(mclk),
    .srst(srst),
    .event_set(rise),
    .clear(rd_status),
    .irq_mask(irqmask_reg),
    .status(status),
    .irq(irq)
  );

  assign comparator_fall_req = reqs[PIE_BIT_CMPF];
  assign counter_array_req = reqs[PIE_BIT_PCA];
  assign conversion_done_req = reqs[PIE_BIT_CONV];
  assign window_compare_req = reqs[PIE_BIT_WIN];
  assign reg_rdata = rdata_reg;

  a_cmpf_gate: assert property (@(posedge mclk) disable iff (srst)
    comparator_fall_req == $past(comparator_fall_flag & comparator_fall_int_enable))
    else $error("comparator request not gated by its enable");
  a_pca_gate: assert property (@(posedge mclk) disable iff (srst)
    !$past(counter_array_int_enable) |-> !counter_array_req)
    else $error("counter array request passed while disabled");
  a_pca_pass: assert property (@(posedge mclk) disable iff (srst)
    $past(counter_array_int_enable & counter_array_flag) |-> counter_array_req)
    else $error("counter array request not forwarded");
  a_conv_gate: assert property (@(posedge mclk) disable iff (srst)
    conversion_done_req == $past(conversion_done_flag & conversion_done_int_enable))
    else $error("conversion request not gated by its enable");
  a_win_block: assert property (@(posedge mclk) disable iff (srst)
    !$past(window_compare_int_enable) |-> !window_compare_req)
    else $error("window request passed while disabled");
  sequence s_pending_enabled;
    conversion_done_flag && !conversion_done_int_enable ##1
    conversion_done_flag && conversion_done_int_enable;
  endsequence
  a_pending_late: assert property (@(posedge mclk) disable iff (srst)
    s_pending_enabled |=> conversion_done_req)
    else $error("pending flag not forwarded after enable");
  a_irq_level: assert property (@(posedge mclk) disable iff (srst)
    irq == |(status & irqmask_reg))
    else $error("irq does not follow masked status");
  a_read_data: assert property (@(posedge mclk) disable iff (srst)
    reg_rd && hit(reg_addr, PIE_ADDR_ENABLE) |=> reg_rdata[PIE_NSRC-1:0] == $past(enable_reg))
    else $error("enable readback wrong");

  // the map fixes four bit positions, so no other source count fits the bus
  if (PIE_NSRC != PIE_BIT_CMPF + 1 || PIE_DW <= PIE_NSRC) begin : g_bad_map
    $error("register map needs four sources below the data width");
  end

  // per-source checks, one set for each mask bit
  for (genvar i = 0; i < PIE_NSRC; i++) begin : g_src_chk
    a_gate_bit: assert property (@(posedge mclk) disable iff (srst)
      reqs[i] == $past(flags[i] & enable_reg[i]))
      else $error("request does not follow flag and enable");
    a_block_bit: assert property (@(posedge mclk) disable iff (srst)
      !enable_reg[i] |=> !reqs[i])
      else $error("request passed while its enable was clear");
    a_pass_bit: assert property (@(posedge mclk) disable iff (srst)
      flags[i] && enable_reg[i] |=> reqs[i])
      else $error("enabled flag not forwarded");
    a_no_flag: assert property (@(posedge mclk) disable iff (srst)
      !flags[i] |=> !reqs[i])
      else $error("request raised with its flag low");
    a_rise_sets: assert property (@(posedge mclk) disable iff (srst)
      rise[i] |=> status[i])
      else $error("forwarded request did not set its status bit");
    a_edge_once: assert property (@(posedge mclk) disable iff (srst)
      rise[i] |=> !rise[i])
      else $error("held request counted twice");
    a_status_keeps: assert property (@(posedge mclk) disable iff (srst)
      status[i] && !rd_status |=> status[i])
      else $error("status bit dropped without a read");
    a_status_cause: assert property (@(posedge mclk) disable iff (srst)
      !status[i] && !rise[i] |=> !status[i])
      else $error("status bit set with no request edge");
    a_flag_pending: assert property (@(posedge mclk) disable iff (srst)
      flags[i] && !enable_reg[i] ##1 flags[i] && enable_reg[i] |=> reqs[i])
      else $error("pending flag not forwarded once enabled");
  end

  // register port: a write lands on the next edge, every other cycle holds
  sequence s_wr_enable;
    reg_wr && hit(reg_addr, PIE_ADDR_ENABLE);
  endsequence
  sequence s_wr_irqmask;
    reg_wr && hit(reg_addr, PIE_ADDR_IRQMASK);
  endsequence
  a_enable_write: assert property (@(posedge mclk) disable iff (srst)
    s_wr_enable |=> enable_reg == $past(reg_wdata[PIE_NSRC-1:0]))
    else $error("enable mask write lost");
  a_enable_hold: assert property (@(posedge mclk) disable iff (srst)
    !(reg_wr && hit(reg_addr, PIE_ADDR_ENABLE)) |=> $stable(enable_reg))
    else $error("enable mask changed without a write");
  a_irqmask_write: assert property (@(posedge mclk) disable iff (srst)
    s_wr_irqmask |=> irqmask_reg == $past(reg_wdata[PIE_NSRC-1:0]))
    else $error("irq mask write lost");
  a_irqmask_hold: assert property (@(posedge mclk) disable iff (srst)
    !(reg_wr && hit(reg_addr, PIE_ADDR_IRQMASK)) |=> $stable(irqmask_reg))
    else $error("irq mask changed without a write");

  // read data stand for one cycle only and are zero otherwise
  sequence s_rd_pending;
    reg_rd && hit(reg_addr, PIE_ADDR_PENDING);
  endsequence
  sequence s_rd_status;
    reg_rd && hit(reg_addr, PIE_ADDR_STATUS);
  endsequence
  sequence s_rd_irqmask;
    reg_rd && hit(reg_addr, PIE_ADDR_IRQMASK);
  endsequence
  a_read_pending: assert property (@(posedge mclk) disable iff (srst)
    s_rd_pending |=> reg_rdata[PIE_NSRC-1:0] == $past(flags))
    else $error("pending readback wrong");
  a_read_status: assert property (@(posedge mclk) disable iff (srst)
    s_rd_status |=> reg_rdata[PIE_NSRC-1:0] == $past(status))
    else $error("status readback wrong");
  a_read_irqmask: assert property (@(posedge mclk) disable iff (srst)
    s_rd_irqmask |=> reg_rdata[PIE_NSRC-1:0] == $past(irqmask_reg))
    else $error("irq mask readback wrong");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (srst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data stood longer than one cycle");
  a_rdata_upper: assert property (@(posedge mclk) disable iff (srst)
    reg_rdata[PIE_DW-1:PIE_NSRC] == '0)
    else $error("unused read bits not zero");

  // irq moves only through status or the mask; a read that meets a new edge keeps it
  a_status_clear: assert property (@(posedge mclk) disable iff (srst)
    s_rd_status |=> status == $past(rise))
    else $error("status not cleared by its read");
  a_clear_quiet: assert property (@(posedge mclk) disable iff (srst)
    s_rd_status ##0 (rise == PIE_ZERO) |=> !irq)
    else $error("irq stayed up after a clearing read");
  a_irq_quiet: assert property (@(posedge mclk) disable iff (srst)
    irqmask_reg == PIE_ZERO |-> !irq)
    else $error("irq raised with every source masked");
  a_irq_needs_status: assert property (@(posedge mclk) disable iff (srst)
    status == PIE_ZERO |-> !irq)
    else $error("irq raised with no status pending");
  a_irq_stays: assert property (@(posedge mclk) disable iff (srst)
    irq && !rd_status && !wr_irqmask |=> irq)
    else $error("irq dropped without a read or mask write");
  a_irq_stays_low: assert property (@(posedge mclk) disable iff (srst)
    !irq && rise == PIE_ZERO && !wr_irqmask |=> !irq)
    else $error("irq raised with no new event");

  // one event walk per source: request rises, status stands next cycle, irq stands in that same cycle
  sequence s_cmpf_rises;
    !comparator_fall_req ##1 comparator_fall_req;
  endsequence
  sequence s_pca_rises;
    !counter_array_req ##1 counter_array_req;
  endsequence
  sequence s_conv_rises;
    !conversion_done_req ##1 conversion_done_req;
  endsequence
  sequence s_win_rises;
    !window_compare_req ##1 window_compare_req;
  endsequence
  a_cmpf_event: assert property (@(posedge mclk) disable iff (srst)
    s_cmpf_rises ##1 irqmask_reg[PIE_BIT_CMPF] |-> status[PIE_BIT_CMPF] && irq)
    else $error("comparator event not recorded");
  a_pca_event: assert property (@(posedge mclk) disable iff (srst)
    s_pca_rises ##1 irqmask_reg[PIE_BIT_PCA] |-> status[PIE_BIT_PCA] && irq)
    else $error("counter array event not recorded");
  a_conv_event: assert property (@(posedge mclk) disable iff (srst)
    s_conv_rises ##1 irqmask_reg[PIE_BIT_CONV] |-> status[PIE_BIT_CONV] && irq)
    else $error("conversion event not recorded");
  a_win_event: assert property (@(posedge mclk) disable iff (srst)
    s_win_rises ##1 irqmask_reg[PIE_BIT_WIN] |-> status[PIE_BIT_WIN] && irq)
    else $error("window event not recorded");

  // clearing an enable drops its request on the next edge, the flag still up
  a_cmpf_block: assert property (@(posedge mclk) disable iff (srst)
    comparator_fall_flag && $fell(comparator_fall_int_enable) |=> !comparator_fall_req)
    else $error("comparator request outlived its enable");
  a_pca_block: assert property (@(posedge mclk) disable iff (srst)
    counter_array_flag && $fell(counter_array_int_enable) |=> !counter_array_req)
    else $error("counter array request outlived its enable");
  a_conv_block: assert property (@(posedge mclk) disable iff (srst)
    conversion_done_flag && $fell(conversion_done_int_enable) |=> !conversion_done_req)
    else $error("conversion request outlived its enable");
  a_win_block_late: assert property (@(posedge mclk) disable iff (srst)
    window_compare_flag && $fell(window_compare_int_enable) |=> !window_compare_req)
    else $error("window request outlived its enable");

  // a flag left pending while masked goes out on the edge after its enable is set
  a_cmpf_late: assert property (@(posedge mclk) disable iff (srst)
    comparator_fall_flag && $rose(comparator_fall_int_enable) |=> comparator_fall_req)
    else $error("pending comparator flag not forwarded");
  a_pca_late: assert property (@(posedge mclk) disable iff (srst)
    counter_array_flag && $rose(counter_array_int_enable) |=> counter_array_req)
    else $error("pending counter array flag not forwarded");
  a_conv_late: assert property (@(posedge mclk) disable iff (srst)
    conversion_done_flag && $rose(conversion_done_int_enable) |=> conversion_done_req)
    else $error("pending conversion flag not forwarded");
  a_win_late: assert property (@(posedge mclk) disable iff (srst)
    window_compare_flag && $rose(window_compare_int_enable) |=> window_compare_req)
    else $error("pending window flag not forwarded");

  // reset leaves every register and output at rest, also in mid-run
  a_reset_regs: assert property (@(posedge mclk)
    $past(srst) |-> enable_reg == PIE_ENABLE_RST && irqmask_reg == PIE_IRQMASK_RST)
    else $error("mask registers not at rest after reset");
  a_reset_outs: assert property (@(posedge mclk)
    $past(srst) |-> reqs == PIE_ZERO && status == PIE_ZERO && reg_rdata == '0)
    else $error("outputs not at rest after reset");
endmodule
`default_nettype wire

// [logic/pie_pkg.sv]
// constants of the peripheral interrupt-enable mask
package pie_pkg;
  localparam int unsigned PIE_NSRC = 4;
  localparam int unsigned PIE_AW = 2;
  localparam int unsigned PIE_DW = 8;
  // bit positions of the enable mask
  localparam int unsigned PIE_BIT_WIN = 0;
  localparam int unsigned PIE_BIT_CONV = 1;
  localparam int unsigned PIE_BIT_PCA = 2;
  localparam int unsigned PIE_BIT_CMPF = 3;
  // register addresses
  localparam logic [PIE_AW-1:0] PIE_ADDR_ENABLE = 2'h0;
  localparam logic [PIE_AW-1:0] PIE_ADDR_PENDING = 2'h1;
  localparam logic [PIE_AW-1:0] PIE_ADDR_STATUS = 2'h2;
  localparam logic [PIE_AW-1:0] PIE_ADDR_IRQMASK = 2'h3;
  // reset values
  localparam logic [PIE_NSRC-1:0] PIE_ENABLE_RST = 4'h0;
  localparam logic [PIE_NSRC-1:0] PIE_IRQMASK_RST = 4'h0;
  localparam logic [PIE_NSRC-1:0] PIE_ZERO = 4'h0;
endpackage

// [logic/pie_gate.sv]
// one gate stage: registered enabled request per source
`timescale 1ns/1ps
`default_nettype none
module pie_gate
  import pie_pkg::*;
#(
  parameter int unsigned N = PIE_NSRC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // flags and enables
  input wire logic [N-1:0] flag,
  input wire logic [N-1:0] enable,
  // gated requests
  output logic [N-1:0] req
);
  // a zero-wide gate has nothing to forward
  if (N < 1) begin : g_bad_n
    $error("gate needs at least one source");
  end
  logic [N-1:0] req_reg;
  logic [N-1:0] req_next;
  generate
    for (genvar i = 0; i < N; i++) begin : g_bit
      // enable only gates the path, the flag itself is untouched
      assign req_next[i] = flag[i] & enable[i];
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (srst) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end
  assign req = req_reg;
endmodule
`default_nettype wire

// [logic/pie_status.sv]
// sticky event status with clear-on-read and masked interrupt
`timescale 1ns/1ps
`default_nettype none
module pie_status
  import pie_pkg::*;
#(
  parameter int unsigned N = PIE_NSRC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // events and controls
  input wire logic [N-1:0] event_set,
  input wire logic clear,
  input wire logic [N-1:0] irq_mask,
  // results
  output logic [N-1:0] status,
  output logic irq
);
  // the clear value is cut from the package constant, so N cannot exceed it
  if (N < 1 || N > PIE_NSRC) begin : g_bad_n
    $error("status width outside the supported range");
  end
  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;
  // set wins over a read-clear in the same cycle
  assign status_next = (clear ? PIE_ZERO[N-1:0] : status_reg) | event_set;
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end
  assign status = status_reg;
  assign irq = |(status_reg & irq_mask);
endmodule
`default_nettype wire

// [tb/pie_flag_src.sv]
// flag source model: level flags raised and dropped on command
`timescale 1ns/1ps
`default_nettype none
module pie_flag_src
  import pie_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // commands from the bench
  input wire logic [PIE_NSRC-1:0] flag_cmd,
  // flag levels, bit 3 comparator fall down to bit 0 window
  output logic [PIE_NSRC-1:0] flag
);
  // flags set whatever the enables hold
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag <= PIE_ZERO;
    end else begin
      flag <= flag_cmd;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_peripheral_interrupt_enable_mask.sv]
// testbench of the peripheral interrupt-enable mask
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_interrupt_enable_mask;
  import pie_pkg::*;
  logic mclk, srst, reg_wr, reg_rd, irq;
  logic [PIE_AW-1:0] reg_addr;
  logic [PIE_DW-1:0] reg_wdata, reg_rdata, d;
  logic [PIE_NSRC-1:0] flag_cmd, flag;
  wire [PIE_NSRC-1:0] req;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  pie_flag_src src (.mclk(mclk), .srst(srst), .flag_cmd(flag_cmd), .flag(flag));
  pie_top DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_fall_flag(flag[3]), .counter_array_flag(flag[2]),
    .conversion_done_flag(flag[1]), .window_compare_flag(flag[0]),
    .comparator_fall_req(req[3]), .counter_array_req(req[2]),
    .conversion_done_req(req[1]), .window_compare_req(req[0]), .irq(irq));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [PIE_DW-1:0] seen, input logic [PIE_DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [PIE_AW-1:0] a, input logic [PIE_DW-1:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [PIE_AW-1:0] a, output logic [PIE_DW-1:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // cut a hang short well past the sixty-odd cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, flag_cmd} = '0;
    srst = 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd(PIE_ADDR_ENABLE, d);
    check(d, 8'h00);
    rd(PIE_ADDR_IRQMASK, d);
    check(d, 8'h00);
    @(posedge mclk);
    flag_cmd <= 4'hF;
    repeat (3) @(posedge mclk);
    #1 check({4'h0, req}, 8'h00);
    rd(PIE_ADDR_PENDING, d);
    check(d, 8'h0F);
    // pending flags are forwarded once their enable alone is set
    for (int i = 0; i < 4; i++) begin
      wr(PIE_ADDR_ENABLE, 8'h01 << i);
      repeat (2) @(posedge mclk);
      #1 check({4'h0, req}, 8'h01 << i);
    end
    wr(PIE_ADDR_IRQMASK, 8'hFF);
    rd(PIE_ADDR_IRQMASK, d);
    check(d, 8'h0F);
    check({7'h00, irq}, 8'h01);
    wr(PIE_ADDR_PENDING, 8'h00);
    rd(PIE_ADDR_PENDING, d);
    check(d, 8'h0F);
    rd(PIE_ADDR_STATUS, d);
    check(d, 8'h0F);
    @(posedge mclk);
    #1 check({7'h00, irq}, 8'h00);
    wr(PIE_ADDR_IRQMASK, 8'h00);
    wr(PIE_ADDR_ENABLE, 8'h0F);
    repeat (3) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h00);
    wr(PIE_ADDR_IRQMASK, 8'h01);
    repeat (2) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h01);
    rd(PIE_ADDR_STATUS, d);
    check(d, 8'h07);
    @(posedge mclk);
    #1 check(reg_rdata, 8'h00);
    // reset in mid-run puts every register and output back to rest
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1 check({3'h0, irq, req}, 8'h00);
    rd(PIE_ADDR_ENABLE, d);
    check(d, 8'h00);
    rd(PIE_ADDR_IRQMASK, d);
    check(d, 8'h00);
    rd(PIE_ADDR_STATUS, d);
    check(d, 8'h00);
    rd(PIE_ADDR_PENDING, d);
    check(d, 8'h0F);
    #1 check({4'h0, req}, 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
